// >>> design/charge_enable_gate.v
/*
 Combines the charge enable conditions into one registered level.
 Assumes all inputs synchronous to clk_sys.
*/
`timescale 1ns/100ps
`include "charger_input_control_consts.vh"
module charge_enable_gate (
    // Clock and reset
    input wire clk_sys,
    input wire arst_n,
    // Conditions
    input wire charge_enable_n,
    input wire charge_enable_bit,
    input wire [5:0] charge_current_code,
    input wire thermistor_ok,
    // Result
    output reg charge_allowed
);
    // All conditions must hold together
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            charge_allowed <= 1'b0;
        end else begin
            charge_allowed <= !charge_enable_n && charge_enable_bit && (|charge_current_code) && thermistor_ok;
        end
    end
endmodule // charge_enable_gate

// >>> design/charger_input_control_consts.vh
/*
 Constants for the two charger input and control configuration registers.
 Assumes a byte-wide register port driven by the serial bus front end.
*/
// Overview of operation
// - Input-control bit 7 enables input high impedance, defaults to 0 and clears on register reset or watchdog expiry.
// - Input-control bit 6 set makes the thermistor count as always good for charge enabling, 0 by default.
// - While the thermistor is ignored the reported thermistor fault code is all zeros.
// - Input-control bit 5 reads 1 when remote sense was not detected and 0 when it was detected.
// - Host may write 0 to the remote-sense disable bit and the device then starts a new remote-sense detection.
// - The 5-bit input current limit is 100 mA plus weights 1600, 800, 400, 200 and 100 mA of set bits.
// - The input current limit resets to the 2400 mA code and only a register reset restores it.
// - After input source detection the device loads 500 mA if the source select pin is high, else 2.4 A.
// - Control bit 7 disables pulse skipping, defaults to 0 and only a register reset clears it.
// - Writing 1 to the watchdog kick bit restarts the watchdog and the device clears the bit itself.
// - Charging is enabled only with the charge enable pin low, charge enable bit 1 and nonzero charge current.
// - The 3-bit system minimum voltage codes 3.0 to 3.7 V and only a register reset restores it.
// - The system minimum voltage defaults to code 101, 3.5 V.
// - The charger control register at offset 01h resets to 1Ah and is readable and writable, except that the kick bit 6 clears itself.
`ifndef CHARGER_INPUT_CONTROL_CONSTS_VH
`define CHARGER_INPUT_CONTROL_CONSTS_VH
`define ADDR_INPUT_LIMIT_CONTROL 8'h00
`define ADDR_CHARGER_CONTROL_ZERO 8'h01
`define RESET_INPUT_LIMIT_CONTROL 8'h17
`define RESET_CHARGER_CONTROL_ZERO 8'h1a
`define BIT_HIGH_IMPEDANCE 7
`define BIT_THERMISTOR_IGNORE 6
`define BIT_REMOTE_SENSE_DISABLE 5
`define LIMIT_MSB 4
`define BIT_PULSE_SKIP_DISABLE 7
`define BIT_WATCHDOG_KICK 6
`define BIT_CHARGE_ENABLE 4
`define SYSMIN_MSB 3
`define SYSMIN_LSB 1
`define LIMIT_CODE_500MA 5'h04
`define LIMIT_CODE_2400MA 5'h17
`define THERMISTOR_NORMAL 3'h0
`endif

// >>> design/charger_input_control_regs.v
/*
 Input-limit control and charger control registers with their side effects.
 The input-limit register holds the high-impedance enable, the thermistor-ignore option,
 the remote-sense disable status and the 5-bit input current limit. The charger control
 register holds the pulse-skip disable, the self-clearing watchdog kick, the charge enable
 bit, the system minimum voltage and two reserved bits that only store what is written.
 Besides host writes, the registers are changed by a register reset (all fields), by
 watchdog expiry (high impedance, kick and charge enable only), by the end of input source
 detection (current limit) and by the result of a remote-sense detection (disable bit).
 In one cycle a register reset beats watchdog expiry, which beats the detection updates,
 which beat a host write.
 Every field that leaves the block is registered, so outputs lag the registers by a cycle.
 Assumes a byte register port from the serial front end, one-cycle strobes, synchronous inputs.
 Assumes the front end turns ack into an acknowledge bit and nack into a refused address.
 Assumes watchdog_expired, source_detect_done and remote_sense_result_valid are one-cycle pulses.
 Assumes the host waits for source detection to finish before writing a new current limit.
*/
`timescale 1ns/100ps
`include "charger_input_control_consts.vh"
module charger_input_control_regs (
    // Clock and reset
    input wire clk_sys,
    input wire arst_n,
    // Register port
    input wire reg_write,
    input wire reg_read,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg reg_ack,
    output reg reg_nack,
    // Reset sources
    input wire register_reset,
    input wire watchdog_expired,
    // Input source detection
    input wire source_detect_done,
    input wire source_select_pin,
    // Remote sense detection
    input wire remote_sense_detected,
    input wire remote_sense_result_valid,
    // Charge conditions
    input wire charge_enable_n,
    input wire [5:0] charge_current_code,
    input wire thermistor_ok,
    input wire [2:0] thermistor_fault_raw,
    // Outputs to regulation logic
    output reg input_high_impedance,
    output reg pulse_skip_disable,
    output reg [4:0] input_current_limit,
    output reg [2:0] system_min_voltage,
    output reg remote_sense_use_battery_pin,
    output reg remote_sense_start,
    output reg watchdog_restart,
    output reg [2:0] thermistor_fault_code,
    output wire charge_allowed
);
    reg [7:0] input_limit_control;
    reg [7:0] charger_control_zero;
    reg [7:0] next_read;
    wire hit_input;
    wire hit_control;
    wire thermistor_effective_ok;
    wire write_input;
    wire write_control;
    wire access_any;
    wire access_mapped;

    // Register defaults kept as words so single fields can be picked out
    localparam [7:0] INPUT_DEFAULT = `RESET_INPUT_LIMIT_CONTROL;
    localparam [7:0] CONTROL_DEFAULT = `RESET_CHARGER_CONTROL_ZERO;
    localparam [4:0] LIMIT_DEFAULT = INPUT_DEFAULT[`LIMIT_MSB:0];
    localparam [2:0] SYSMIN_DEFAULT = CONTROL_DEFAULT[`SYSMIN_MSB:`SYSMIN_LSB];
    localparam [0:0] CHARGE_ENABLE_DEFAULT = CONTROL_DEFAULT[`BIT_CHARGE_ENABLE];

    // Address compare used by read and write paths
    function is_addr;
        input [7:0] addr;
        input [7:0] target;
        begin
            is_addr = (addr == target);
        end
    endfunction

    assign hit_input = is_addr(reg_addr, `ADDR_INPUT_LIMIT_CONTROL);
    assign hit_control = is_addr(reg_addr, `ADDR_CHARGER_CONTROL_ZERO);

    // Strobe qualifiers shared by the register, answer and event logic
    assign write_input = reg_write && hit_input;
    assign write_control = reg_write && hit_control;
    assign access_any = reg_write || reg_read;
    assign access_mapped = hit_input || hit_control;

    // Input-limit control register
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            input_limit_control <= `RESET_INPUT_LIMIT_CONTROL;
        end else if (register_reset) begin
            input_limit_control <= `RESET_INPUT_LIMIT_CONTROL;
        end else begin
            if (write_input) begin
                input_limit_control <= reg_wdata;
            end
            if (source_detect_done) begin
                // Automatic update wins over a host write in the same cycle
                input_limit_control[`LIMIT_MSB:0] <= source_select_pin ?
                    `LIMIT_CODE_500MA : `LIMIT_CODE_2400MA;
            end
            if (remote_sense_result_valid) begin
                input_limit_control[`BIT_REMOTE_SENSE_DISABLE] <= !remote_sense_detected;
            end
            if (watchdog_expired) begin
                input_limit_control[`BIT_HIGH_IMPEDANCE] <= 1'b0;
            end
        end
    end

    // Charger control register; watchdog restores kick and charge enable bits only
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            charger_control_zero <= `RESET_CHARGER_CONTROL_ZERO;
        end else if (register_reset) begin
            charger_control_zero <= `RESET_CHARGER_CONTROL_ZERO;
        end else begin
            if (write_control) begin
                charger_control_zero <= reg_wdata;
            end else if (charger_control_zero[`BIT_WATCHDOG_KICK]) begin
                charger_control_zero[`BIT_WATCHDOG_KICK] <= 1'b0;
            end
            if (watchdog_expired) begin
                charger_control_zero[`BIT_WATCHDOG_KICK] <= 1'b0;
                charger_control_zero[`BIT_CHARGE_ENABLE] <= CHARGE_ENABLE_DEFAULT;
            end
        end
    end

    // Read mux returning zero for unmapped addresses
    always @* begin
        next_read = 8'h00;
        if (hit_input) begin
            next_read = input_limit_control;
        end else if (hit_control) begin
            next_read = charger_control_zero;
        end
    end

    // Register port answer one cycle after the strobe
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
            reg_ack <= 1'b0;
            reg_nack <= 1'b0;
        end else begin
            reg_ack <= access_any && access_mapped;
            reg_nack <= access_any && !access_mapped;
            if (reg_read) begin
                reg_rdata <= next_read;
            end
        end
    end

    assign thermistor_effective_ok = thermistor_ok || input_limit_control[`BIT_THERMISTOR_IGNORE];

    // Registered copies of the fields that steer the regulation loops
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            input_high_impedance <= 1'b0;
            pulse_skip_disable <= 1'b0;
            input_current_limit <= LIMIT_DEFAULT;
            system_min_voltage <= SYSMIN_DEFAULT;
            remote_sense_use_battery_pin <= 1'b0;
        end else begin
            input_high_impedance <= input_limit_control[`BIT_HIGH_IMPEDANCE];
            pulse_skip_disable <= charger_control_zero[`BIT_PULSE_SKIP_DISABLE];
            input_current_limit <= input_limit_control[`LIMIT_MSB:0];
            system_min_voltage <= charger_control_zero[`SYSMIN_MSB:`SYSMIN_LSB];
            remote_sense_use_battery_pin <= input_limit_control[`BIT_REMOTE_SENSE_DISABLE];
        end
    end

    // New remote-sense detection when the host drops the disable bit, unless a register reset swallows the write
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            remote_sense_start <= 1'b0;
        end else begin
            remote_sense_start <= write_input && !register_reset
                && !reg_wdata[`BIT_REMOTE_SENSE_DISABLE]
                && input_limit_control[`BIT_REMOTE_SENSE_DISABLE];
        end
    end

    // One restart pulse per kick, since the kick bit clears a cycle after it is set
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            watchdog_restart <= 1'b0;
        end else begin
            watchdog_restart <= charger_control_zero[`BIT_WATCHDOG_KICK];
        end
    end

    // Fault code forced to normal while the thermistor is ignored
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            thermistor_fault_code <= `THERMISTOR_NORMAL;
        end else if (input_limit_control[`BIT_THERMISTOR_IGNORE]) begin
            thermistor_fault_code <= `THERMISTOR_NORMAL;
        end else begin
            thermistor_fault_code <= thermistor_fault_raw;
        end
    end

    // Charge enable decision
    charge_enable_gate u_gate (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .charge_enable_n(charge_enable_n),
        .charge_enable_bit(charger_control_zero[`BIT_CHARGE_ENABLE]),
        .charge_current_code(charge_current_code),
        .thermistor_ok(thermistor_effective_ok),
        .charge_allowed(charge_allowed)
    );
endmodule // charger_input_control_regs

// >>> sim/detect_model.sv
/*
 Model of the source and remote-sense detection circuits.
 Assumes requests arrive as one-cycle pulses on clk_sys.
*/
`timescale 1ns/100ps
module detect_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Requests
    input wire logic detect_req,
    input wire logic remote_sense_start,
    // Results
    output logic source_detect_done,
    output logic remote_sense_result_valid,
    output logic remote_sense_detected
);
    // Answer each request one cycle later; remote sense never found
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            source_detect_done <= 1'b0;
            remote_sense_result_valid <= 1'b0;
            remote_sense_detected <= 1'b1;
        end else begin
            source_detect_done <= detect_req;
            remote_sense_result_valid <= remote_sense_start;
            remote_sense_detected <= 1'b0;
        end
    end
endmodule // detect_model

// >>> sim/input_control_checker_assertions.sv
/*
 Checker for the charger input and control registers.
 Assumes it is bound to the register block and sees only its ports.
*/
`timescale 1ns/100ps
module input_control_checker (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Register port
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_ack,
    input wire logic reg_nack,
    // Reset sources and detection
    input wire logic register_reset,
    input wire logic watchdog_expired,
    input wire logic source_detect_done,
    input wire logic source_select_pin,
    // Charge conditions
    input wire logic charge_enable_n,
    input wire logic [5:0] charge_current_code,
    // Field outputs
    input wire logic charge_allowed,
    input wire logic input_high_impedance,
    input wire logic watchdog_restart,
    input wire logic [4:0] input_current_limit,
    input wire logic [2:0] system_min_voltage,
    input wire logic [2:0] thermistor_fault_code
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Port answers and read data
    a_mapped_gets_ack: assert property ((reg_write || reg_read) && reg_addr < 8'h02 && !register_reset |=> reg_ack)
        else $error("mapped access not acknowledged");
    a_unmapped_gets_nack: assert property ((reg_write || reg_read) && reg_addr > 8'h01 |=> reg_nack && !reg_ack)
        else $error("unmapped access not refused");
    a_rdata_holds: assert property ($changed(reg_rdata) |-> $past(reg_read))
        else $error("read data moved without a read");
    // Field side effects
    a_kick_restarts: assert property (reg_write && reg_addr == 8'h01 && reg_wdata[6] && !register_reset
        && !watchdog_expired |-> ##2 watchdog_restart ##1 !watchdog_restart)
        else $error("kick did not give one restart pulse");
    a_ignore_zero_fault: assert property (reg_write && reg_addr == 8'h00 && reg_wdata[6] && !register_reset
        |-> ##2 thermistor_fault_code == 3'h0)
        else $error("fault code not normal while ignored");
    a_hiz_cleared_watchdog: assert property (watchdog_expired |-> ##2 !input_high_impedance)
        else $error("high impedance survived watchdog");
    a_limit_after_detect: assert property (source_detect_done && !register_reset
        |-> ##2 input_current_limit == (source_select_pin ? 5'h04 : 5'h17))
        else $error("limit not loaded after detection");
    a_defaults_restored: assert property (register_reset
        |-> ##2 system_min_voltage == 3'h5 && input_current_limit == 5'h17)
        else $error("defaults not restored");
    a_charge_gate: assert property (charge_allowed
        |-> !$past(charge_enable_n) && $past(charge_current_code) != 6'h00)
        else $error("charging allowed without its conditions");
endmodule // input_control_checker
bind charger_input_control_regs input_control_checker chk (.*);

// >>> sim/tb_top.sv
/*
 Testbench for the charger input and control registers.
 Assumes one-cycle strobes answered by ack or nack one cycle later.
*/
`timescale 1ns/100ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
    $display("[FAIL] %s expected %h seen %h", n, e, a); end end
module tb_top;
    logic clk_sys, arst_n, reg_write, reg_read, reg_ack, reg_nack, register_reset, watchdog_expired;
    logic detect_req, source_select_pin, source_detect_done, remote_sense_detected, remote_sense_result_valid;
    logic charge_enable_n, thermistor_ok, remote_sense_start, watchdog_restart, input_high_impedance;
    logic pulse_skip_disable, charge_allowed, remote_sense_use_battery_pin;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [5:0] charge_current_code;
    logic [4:0] input_current_limit;
    logic [2:0] thermistor_fault_raw, system_min_voltage, thermistor_fault_code;
    int miscompares, checks_done;
    charger_input_control_regs DUT (.*);
    detect_model partner (.*);
    // One access: strobe for one cycle, answer seen at the next falling edge
    task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_write = w;
        reg_read = !w;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_write = 0;
        reg_read = 0;
        `CHK("ack", a < 8'h02, reg_ack)
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        acc(0, a, 8'h00);
        `CHK("rdata", e, reg_rdata)
    endtask
    task detect(input logic p, input logic [7:0] e);
        source_select_pin = p;
        detect_req = 1;
        @(negedge clk_sys);
        detect_req = 0;
        repeat (2) @(negedge clk_sys);
        rd(8'h00, e);
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Clock
    initial begin
        clk_sys = 0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Watchdog on the whole run
    initial begin
        #160000;
        miscompares++;
        stop_test;
    end
    // Test sequence
    initial begin
        {reg_write, reg_read, register_reset, watchdog_expired, detect_req, source_select_pin} = 0;
        reg_addr = 0;
        reg_wdata = 0;
        charge_enable_n = 0;
        charge_current_code = 6'h11;
        thermistor_ok = 1;
        thermistor_fault_raw = 3'h5;
        arst_n = 0;
        repeat (4) @(negedge clk_sys);
        arst_n = 1;
        rd(8'h00, 8'h17);
        rd(8'h01, 8'h1a);
        `CHK("allowed", 1'b1, charge_allowed)
        charge_enable_n = 1;
        repeat (2) @(negedge clk_sys);
        `CHK("allowed", 1'b0, charge_allowed)
        $display("test defaults done");
        acc(1, 8'h01, 8'hff);
        rd(8'h01, 8'hbf);
        `CHK("pulse skip", 1'b1, pulse_skip_disable)
        `CHK("sysmin", 3'h7, system_min_voltage)
        rd(8'h02, 8'h00);
        `CHK("nack", 1'b1, reg_nack)
        $display("test control done");
        acc(1, 8'h00, 8'h80);
        acc(1, 8'h01, 8'h00);
        `CHK("hiz", 1'b1, input_high_impedance)
        watchdog_expired = 1;
        @(negedge clk_sys);
        watchdog_expired = 0;
        rd(8'h00, 8'h00);
        rd(8'h01, 8'h10);
        $display("test watchdog done");
        detect(1, 8'h04);
        detect(0, 8'h17);
        acc(1, 8'h00, 8'h45);
        rd(8'h00, 8'h45);
        `CHK("limit", 5'h05, input_current_limit)
        `CHK("fault", 3'h0, thermistor_fault_code)
        acc(1, 8'h00, 8'h20);
        acc(1, 8'h00, 8'h00);
        repeat (3) @(negedge clk_sys);
        rd(8'h00, 8'h20);
        `CHK("battery pin", 1'b1, remote_sense_use_battery_pin)
        `CHK("fault", 3'h5, thermistor_fault_code)
        $display("test detection done");
        acc(1, 8'h01, 8'h83);
        register_reset = 1;
        @(negedge clk_sys);
        register_reset = 0;
        rd(8'h00, 8'h17);
        rd(8'h01, 8'h1a);
        $display("test register reset done");
        stop_test;
    end
endmodule // tb_top
